//--- stack_machine_control_ops.sv
/*
  Executor for the stack and machine-control operations of an 8-bit core:
  register pair pop, status word push and pop, stack top exchange, stack
  pointer load, interrupt enable and disable, halt and no-op.
  Assumes a byte-wide synchronous memory on clk_sys that returns read data
  in the cycle after the read strobe, and a register port master on clk_sys.
*/
// Chosen here: the strobed register port and the register addresses.
// Notes on behaviour
// - Pair pop loads low register from the stack top, high from the next byte, adds 2, takes 10 states.
// - Pair pop with the stack pointer as target is refused; only general pairs are legal.
// - Status push writes accumulator at pointer-1 and flag byte at pointer-2, subtracts 2, takes 11 states.
// - Flag byte is sign,zero,0,aux,0,parity,1,carry from bit 7 down to bit 0.
// - Status pop restores flags from bits 0,2,4,6,7 of the stack top, accumulator from the next byte, adds 2.
// - Status pop takes 10 states and updates all five flags; pair pop leaves flags alone.
// - Exchange swaps L with the stack top and H with the next byte, pointer unchanged.
// - Stack pointer load copies H:L into the stack pointer.
// - Interrupt enable takes effect only after the following instruction completes.
// - Interrupt disable blocks interrupts as soon as it completes.
// - Halt stops execution and keeps all registers and flags.
// - No-op changes no register or flag.
`timescale 1ns/10ps
`include "smc_cfg.svh"

module stack_machine_control_ops #(
	parameter int STACK_W = 16
) (
	input  logic              clk_sys,
	input  logic              srst,
	input  logic              opStart,
	input  smc_pkg::op_type   opCode,
	input  smc_pkg::pair_type pairSel,
	input  logic              wakeReq,
	output logic              busy_ff,
	output logic              opDone_ff,
	output logic              opRefused_ff,
	output logic              halted_ff,
	output logic              intEnable_ff,
	output logic [15:0]       memAddr_ff,
	output logic [7:0]        memWrData_ff,
	output logic              memWr_ff,
	output logic              memRd_ff,
	input  logic [7:0]        memRdData,
	input  logic [3:0]        regAddr,
	input  logic [7:0]        regWrData,
	input  logic              regWr,
	input  logic              regRd,
	output logic [7:0]        regRdData_ff
);
	import smc_pkg::*;

	generate
		if (STACK_W < 8 || STACK_W > 16) begin : g_bad_width
			$error("STACK_W must lie between 8 and 16");
		end
	endgenerate

	state_type          state_ff;
	state_type          nxt_state;
	op_type             curOp_ff;
	pair_type           curPair_ff;
	logic [4:0]         cnt_ff;
	logic [4:0]         lastCnt_ff;
	logic [7:0]         accReg_ff;
	logic [7:0]         bReg_ff;
	logic [7:0]         cReg_ff;
	logic [7:0]         dReg_ff;
	logic [7:0]         eReg_ff;
	logic [7:0]         hReg_ff;
	logic [7:0]         lReg_ff;
	logic               carryFlag_ff;
	logic               parityFlag_ff;
	logic               auxCarryFlag_ff;
	logic               zeroFlag_ff;
	logic               signFlag_ff;
	logic [STACK_W-1:0] stackPointer_ff;
	logic [7:0]         tmpLo_ff;
	logic [7:0]         tmpHi_ff;
	logic               eiPending_ff;
	logic               wakeMeta_ff;
	logic               wakeSync_ff;
	logic [STACK_W-1:0] spAtStart_ff;
	logic               accept;
	logic               finish;
	logic               stateIdle;
	logic [STACK_W-1:0] spPlus1;
	logic [STACK_W-1:0] spPlus2;
	logic [STACK_W-1:0] spMinus1;
	logic [STACK_W-1:0] spMinus2;
	logic [15:0]        spWide;
	logic [7:0]         flagByte;

	function automatic logic [4:0] opLen(input op_type op);
		case (op)
			OP_POP_PAIR:           opLen = `SMC_LEN_POP_PAIR;
			OP_PUSH_STATUS:        opLen = `SMC_LEN_PUSH_STATUS;
			OP_POP_STATUS:         opLen = `SMC_LEN_POP_STATUS;
			OP_STACK_TOP_EXCHANGE: opLen = `SMC_LEN_EXCHANGE;
			OP_STACK_POINTER_LOAD: opLen = `SMC_LEN_STACK_LOAD;
			OP_HALT:               opLen = `SMC_LEN_HALT;
			default:               opLen = `SMC_LEN_SHORT;
		endcase
	endfunction

	// Packed flag byte; the fixed bits appear in pushed bytes and in register port reads of the flags
	always_comb begin
		flagByte                  = `SMC_RST_BYTE;
		flagByte[`SMC_BIT_CARRY]  = carryFlag_ff;
		flagByte[`SMC_BIT_ONE]    = 1'b1;
		flagByte[`SMC_BIT_PARITY] = parityFlag_ff;
		flagByte[`SMC_BIT_ZERO_A] = 1'b0;
		flagByte[`SMC_BIT_AUX]    = auxCarryFlag_ff;
		flagByte[`SMC_BIT_ZERO_B] = 1'b0;
		flagByte[`SMC_BIT_ZERO]   = zeroFlag_ff;
		flagByte[`SMC_BIT_SIGN]   = signFlag_ff;
	end

	// Plain unsigned adds of the pointer width wrap on their own
	assign spPlus1   = stackPointer_ff + STACK_W'(`SMC_STACK_ONE);
	assign spPlus2   = stackPointer_ff + STACK_W'(`SMC_STACK_TWO);
	assign spMinus1  = stackPointer_ff - STACK_W'(`SMC_STACK_ONE);
	assign spMinus2  = stackPointer_ff - STACK_W'(`SMC_STACK_TWO);
	assign spWide    = 16'(stackPointer_ff);
	assign stateIdle = (state_ff == ST_IDLE);
	assign accept    = opStart && stateIdle && !(opCode == OP_POP_PAIR && pairSel == PAIR_STACK);
	assign finish    = (state_ff == ST_EXEC) && (cnt_ff == lastCnt_ff);

	// Wake pin comes from outside the clock domain
	always_ff @(posedge clk_sys) begin
		if (srst) begin
			wakeMeta_ff <= 1'b0;
			wakeSync_ff <= 1'b0;
		end else begin
			wakeMeta_ff <= wakeReq;
			wakeSync_ff <= wakeMeta_ff;
		end
	end

	always_comb begin
		nxt_state = state_ff;
		case (state_ff)
			ST_IDLE: begin
				if (accept) begin
					nxt_state = ST_EXEC;
				end
			end
			ST_EXEC: begin
				if (finish) begin
					nxt_state = (curOp_ff == OP_HALT) ? ST_HALT : ST_IDLE;
				end
			end
			ST_HALT: begin
				// Only an enabled wake or a reset leaves the halt
				if (wakeSync_ff && intEnable_ff) begin
					nxt_state = ST_IDLE;
				end
			end
			default: nxt_state = ST_IDLE;
		endcase
	end

	// Sequencer
	always_ff @(posedge clk_sys) begin
		if (srst) begin
			state_ff     <= ST_IDLE;
			busy_ff      <= 1'b0;
			halted_ff    <= 1'b0;
			cnt_ff       <= 5'h00;
			lastCnt_ff   <= 5'h00;
			curOp_ff     <= OP_NO_OPERATION;
			curPair_ff   <= PAIR_BC;
			opDone_ff    <= 1'b0;
			opRefused_ff <= 1'b0;
			spAtStart_ff <= STACK_W'(`SMC_RST_STACK);
		end else begin
			state_ff     <= nxt_state;
			busy_ff      <= (nxt_state != ST_IDLE);
			halted_ff    <= (nxt_state == ST_HALT);
			opDone_ff    <= finish;
			opRefused_ff <= opStart && !accept;
			cnt_ff       <= cnt_ff + `SMC_CNT_ONE;
			if (accept) begin
				cnt_ff       <= `SMC_CNT_ONE;
				lastCnt_ff   <= opLen(opCode) - `SMC_CNT_ONE;
				curOp_ff     <= opCode;
				curPair_ff   <= pairSel;
				spAtStart_ff <= stackPointer_ff;
			end
		end
	end

	// Memory strobes and captured stack bytes
	always_ff @(posedge clk_sys) begin
		if (srst) begin
			memRd_ff     <= 1'b0;
			memWr_ff     <= 1'b0;
			memAddr_ff   <= `SMC_RST_STACK;
			memWrData_ff <= `SMC_RST_BYTE;
			tmpLo_ff     <= `SMC_RST_BYTE;
			tmpHi_ff     <= `SMC_RST_BYTE;
		end else begin
			memRd_ff <= 1'b0;
			memWr_ff <= 1'b0;
			if (state_ff == ST_EXEC) begin
				case (curOp_ff)
					OP_POP_PAIR, OP_POP_STATUS, OP_STACK_TOP_EXCHANGE: begin
						if (cnt_ff == `SMC_STEP_RD_LO) begin
							memRd_ff   <= 1'b1;
							memAddr_ff <= spWide;
						end
						if (cnt_ff == `SMC_STEP_RD_HI) begin
							memRd_ff   <= 1'b1;
							memAddr_ff <= 16'(spPlus1);
						end
						if (cnt_ff == `SMC_STEP_CAP_LO) begin
							tmpLo_ff <= memRdData;
						end
						if (cnt_ff == `SMC_STEP_CAP_HI) begin
							tmpHi_ff <= memRdData;
						end
						// Old H and L go out before the registers take the stack bytes
						if (curOp_ff == OP_STACK_TOP_EXCHANGE && cnt_ff == `SMC_STEP_WR_LO) begin
							memWr_ff     <= 1'b1;
							memAddr_ff   <= spWide;
							memWrData_ff <= lReg_ff;
						end
						if (curOp_ff == OP_STACK_TOP_EXCHANGE && cnt_ff == `SMC_STEP_WR_HI) begin
							memWr_ff     <= 1'b1;
							memAddr_ff   <= 16'(spPlus1);
							memWrData_ff <= hReg_ff;
						end
					end
					OP_PUSH_STATUS: begin
						if (cnt_ff == `SMC_STEP_PUSH_ACC) begin
							memWr_ff     <= 1'b1;
							memAddr_ff   <= 16'(spMinus1);
							memWrData_ff <= accReg_ff;
						end
						if (cnt_ff == `SMC_STEP_PUSH_FLAGS) begin
							memWr_ff     <= 1'b1;
							memAddr_ff   <= 16'(spMinus2);
							memWrData_ff <= flagByte;
						end
					end
					default: begin
					end
				endcase
			end
		end
	end

	// Register file; the port may write only while the executor is idle
	always_ff @(posedge clk_sys) begin
		if (srst) begin
			accReg_ff       <= `SMC_RST_BYTE;
			bReg_ff         <= `SMC_RST_BYTE;
			cReg_ff         <= `SMC_RST_BYTE;
			dReg_ff         <= `SMC_RST_BYTE;
			eReg_ff         <= `SMC_RST_BYTE;
			hReg_ff         <= `SMC_RST_BYTE;
			lReg_ff         <= `SMC_RST_BYTE;
			carryFlag_ff    <= 1'b0;
			parityFlag_ff   <= 1'b0;
			auxCarryFlag_ff <= 1'b0;
			zeroFlag_ff     <= 1'b0;
			signFlag_ff     <= 1'b0;
			stackPointer_ff <= STACK_W'(`SMC_RST_STACK);
		end else if (finish) begin
			case (curOp_ff)
				OP_POP_PAIR: begin
					stackPointer_ff <= spPlus2;
					case (curPair_ff)
						PAIR_BC: begin
							cReg_ff <= tmpLo_ff;
							bReg_ff <= tmpHi_ff;
						end
						PAIR_DE: begin
							eReg_ff <= tmpLo_ff;
							dReg_ff <= tmpHi_ff;
						end
						default: begin
							lReg_ff <= tmpLo_ff;
							hReg_ff <= tmpHi_ff;
						end
					endcase
				end
				OP_PUSH_STATUS: stackPointer_ff <= spMinus2;
				OP_POP_STATUS: begin
					carryFlag_ff    <= tmpLo_ff[`SMC_BIT_CARRY];
					parityFlag_ff   <= tmpLo_ff[`SMC_BIT_PARITY];
					auxCarryFlag_ff <= tmpLo_ff[`SMC_BIT_AUX];
					zeroFlag_ff     <= tmpLo_ff[`SMC_BIT_ZERO];
					signFlag_ff     <= tmpLo_ff[`SMC_BIT_SIGN];
					accReg_ff       <= tmpHi_ff;
					stackPointer_ff <= spPlus2;
				end
				OP_STACK_TOP_EXCHANGE: begin
					lReg_ff <= tmpLo_ff;
					hReg_ff <= tmpHi_ff;
				end
				OP_STACK_POINTER_LOAD: stackPointer_ff <= STACK_W'({hReg_ff, lReg_ff});
				default: begin
					// No-op, enable, disable and halt leave every register alone
				end
			endcase
		end else if (regWr && stateIdle) begin
			case (regAddr)
				`SMC_ADDR_ACC: accReg_ff <= regWrData;
				`SMC_ADDR_FLAGS: begin
					carryFlag_ff    <= regWrData[`SMC_BIT_CARRY];
					parityFlag_ff   <= regWrData[`SMC_BIT_PARITY];
					auxCarryFlag_ff <= regWrData[`SMC_BIT_AUX];
					zeroFlag_ff     <= regWrData[`SMC_BIT_ZERO];
					signFlag_ff     <= regWrData[`SMC_BIT_SIGN];
				end
				`SMC_ADDR_B: bReg_ff <= regWrData;
				`SMC_ADDR_C: cReg_ff <= regWrData;
				`SMC_ADDR_D: dReg_ff <= regWrData;
				`SMC_ADDR_E: eReg_ff <= regWrData;
				`SMC_ADDR_H: hReg_ff <= regWrData;
				`SMC_ADDR_L: lReg_ff <= regWrData;
				`SMC_ADDR_STACK_LO: stackPointer_ff <= STACK_W'({spWide[15:8], regWrData});
				`SMC_ADDR_STACK_HI: stackPointer_ff <= STACK_W'({regWrData, spWide[7:0]});
				default: begin
				end
			endcase
		end
	end

	// Interrupt enable with one instruction of delay
	always_ff @(posedge clk_sys) begin
		if (srst) begin
			intEnable_ff <= 1'b0;
			eiPending_ff <= 1'b0;
		end else if (finish) begin
			if (curOp_ff == OP_INTERRUPT_ENABLE) begin
				eiPending_ff <= 1'b1;
			end else if (curOp_ff == OP_INTERRUPT_DISABLE) begin
				intEnable_ff <= 1'b0;
				eiPending_ff <= 1'b0;
			end else if (eiPending_ff) begin
				intEnable_ff <= 1'b1;
				eiPending_ff <= 1'b0;
			end
		end
	end

	always_ff @(posedge clk_sys) begin
		if (srst) begin
			regRdData_ff <= `SMC_RST_BYTE;
		end else if (regRd) begin
			case (regAddr)
				`SMC_ADDR_ACC:      regRdData_ff <= accReg_ff;
				`SMC_ADDR_FLAGS:    regRdData_ff <= flagByte;
				`SMC_ADDR_B:        regRdData_ff <= bReg_ff;
				`SMC_ADDR_C:        regRdData_ff <= cReg_ff;
				`SMC_ADDR_D:        regRdData_ff <= dReg_ff;
				`SMC_ADDR_E:        regRdData_ff <= eReg_ff;
				`SMC_ADDR_H:        regRdData_ff <= hReg_ff;
				`SMC_ADDR_L:        regRdData_ff <= lReg_ff;
				`SMC_ADDR_STACK_LO: regRdData_ff <= spWide[7:0];
				`SMC_ADDR_STACK_HI: regRdData_ff <= spWide[15:8];
				`SMC_ADDR_STATUS:   regRdData_ff <= {4'h0, eiPending_ff, intEnable_ff, halted_ff, busy_ff};
				default:            regRdData_ff <= `SMC_RST_BYTE;
			endcase
		end else begin
			regRdData_ff <= `SMC_RST_BYTE;
		end
	end

	default clocking cb_sys @(posedge clk_sys);
	endclocking
	default disable iff (srst);

	sequence s_pop_pair_go;
		accept && opCode == OP_POP_PAIR;
	endsequence
	sequence s_push_go;
		accept && opCode == OP_PUSH_STATUS;
	endsequence
	sequence s_push_acc_write;
		memWr_ff && memAddr_ff == 16'(spMinus1) && memWrData_ff == accReg_ff;
	endsequence

	property p_pop_pair_done;
		s_pop_pair_go |-> ##10 (opDone_ff && stackPointer_ff == spAtStart_ff + STACK_W'(`SMC_STACK_TWO));
	endproperty
	a_pop_pair_done: assert property (p_pop_pair_done) else $error("pair pop length or pointer wrong");

	property p_pop_refused;
		(opStart && stateIdle && opCode == OP_POP_PAIR && pairSel == PAIR_STACK) |=> (opRefused_ff && !busy_ff);
	endproperty
	a_pop_refused: assert property (p_pop_refused) else $error("pointer pair pop not refused");

	property p_push_writes;
		s_push_go |-> ##2 (s_push_acc_write and memAddr_ff == 16'(spAtStart_ff - STACK_W'(`SMC_STACK_ONE)))
			##1 (memWr_ff && memAddr_ff == 16'(spAtStart_ff - STACK_W'(`SMC_STACK_TWO)) && memWrData_ff == flagByte);
	endproperty
	a_push_writes: assert property (p_push_writes) else $error("status push writes wrong");

	property p_push_done;
		s_push_go |-> ##11 (opDone_ff && stackPointer_ff == spAtStart_ff - STACK_W'(`SMC_STACK_TWO));
	endproperty
	a_push_done: assert property (p_push_done) else $error("status push length or pointer wrong");

	property p_flag_layout;
		memWr_ff && curOp_ff == OP_PUSH_STATUS && cnt_ff == `SMC_STEP_CAP_LO |->
			memWrData_ff[`SMC_BIT_ONE] && !memWrData_ff[`SMC_BIT_ZERO_A] && !memWrData_ff[`SMC_BIT_ZERO_B]
			&& memWrData_ff[`SMC_BIT_CARRY] == carryFlag_ff && memWrData_ff[`SMC_BIT_SIGN] == signFlag_ff;
	endproperty
	a_flag_layout: assert property (p_flag_layout) else $error("flag byte packing wrong");

	property p_pop_status;
		(accept && opCode == OP_POP_STATUS) |-> ##10 (opDone_ff && carryFlag_ff == $past(memRdData[0], 7)
			&& zeroFlag_ff == $past(memRdData[6], 7) && accReg_ff == $past(memRdData, 6));
	endproperty
	a_pop_status: assert property (p_pop_status) else $error("status pop restore wrong");

	property p_exchange;
		(accept && opCode == OP_STACK_TOP_EXCHANGE) |-> ##18 (opDone_ff && stackPointer_ff == spAtStart_ff
			&& lReg_ff == $past(memRdData, 15) && hReg_ff == $past(memRdData, 14));
	endproperty
	a_exchange: assert property (p_exchange) else $error("exchange wrong");

	property p_stack_load;
		(accept && opCode == OP_STACK_POINTER_LOAD) |-> ##5 (opDone_ff
			&& stackPointer_ff == STACK_W'({hReg_ff, lReg_ff}));
	endproperty
	a_stack_load: assert property (p_stack_load) else $error("pointer load wrong");

	property p_enable_deferred;
		(opDone_ff && curOp_ff == OP_INTERRUPT_ENABLE && !$past(intEnable_ff)) |-> !intEnable_ff && eiPending_ff;
	endproperty
	a_enable_deferred: assert property (p_enable_deferred) else $error("enable not deferred");

	property p_disable_now;
		(opDone_ff && curOp_ff == OP_INTERRUPT_DISABLE) |-> !intEnable_ff && !eiPending_ff;
	endproperty
	a_disable_now: assert property (p_disable_now) else $error("disable not immediate");

	property p_halt_hold;
		halted_ff |=> $stable(accReg_ff) && $stable(stackPointer_ff) && $stable(carryFlag_ff) && $stable(hReg_ff);
	endproperty
	a_halt_hold: assert property (p_halt_hold) else $error("state changed during halt");

	property p_nop;
		(accept && opCode == OP_NO_OPERATION) |-> ##4 (opDone_ff && accReg_ff == $past(accReg_ff, 4)
			&& stackPointer_ff == spAtStart_ff && carryFlag_ff == $past(carryFlag_ff, 4));
	endproperty
	a_nop: assert property (p_nop) else $error("no-op changed state");

endmodule // stack_machine_control_ops

//--- smc_cfg.svh
/*
  Constants for the stack and machine-control executor: operation lengths in
  clock states, sequencing steps, flag byte layout and register offsets.
  Assumes one clock state per cycle of clk_sys.
*/
`ifndef SMC_CFG_SVH
`define SMC_CFG_SVH

// Operation lengths in clock states
`define SMC_LEN_POP_PAIR      5'h0A
`define SMC_LEN_PUSH_STATUS   5'h0B
`define SMC_LEN_POP_STATUS    5'h0A
`define SMC_LEN_EXCHANGE      5'h12
`define SMC_LEN_STACK_LOAD    5'h05
`define SMC_LEN_HALT          5'h07
`define SMC_LEN_SHORT         5'h04
`define SMC_CNT_ONE           5'h01

// Sequencing steps, counted from the cycle after acceptance
`define SMC_STEP_RD_LO        5'h01
`define SMC_STEP_RD_HI        5'h02
`define SMC_STEP_CAP_LO       5'h03
`define SMC_STEP_CAP_HI       5'h04
`define SMC_STEP_WR_LO        5'h05
`define SMC_STEP_WR_HI        5'h06
`define SMC_STEP_PUSH_ACC     5'h01
`define SMC_STEP_PUSH_FLAGS   5'h02

// Stack pointer steps
`define SMC_STACK_ONE         5'h01
`define SMC_STACK_TWO         5'h02

// Flag byte layout
`define SMC_BIT_CARRY         3'h0
`define SMC_BIT_ONE           3'h1
`define SMC_BIT_PARITY        3'h2
`define SMC_BIT_ZERO_A        3'h3
`define SMC_BIT_AUX           3'h4
`define SMC_BIT_ZERO_B        3'h5
`define SMC_BIT_ZERO          3'h6
`define SMC_BIT_SIGN          3'h7

// Register port offsets
`define SMC_ADDR_ACC          4'h0
`define SMC_ADDR_FLAGS        4'h1
`define SMC_ADDR_B            4'h2
`define SMC_ADDR_C            4'h3
`define SMC_ADDR_D            4'h4
`define SMC_ADDR_E            4'h5
`define SMC_ADDR_H            4'h6
`define SMC_ADDR_L            4'h7
`define SMC_ADDR_STACK_LO     4'h8
`define SMC_ADDR_STACK_HI     4'h9
`define SMC_ADDR_STATUS       4'hA

// Reset values
`define SMC_RST_BYTE          8'h00
`define SMC_RST_STACK         16'h0000

`endif

//--- smc_pkg.sv
/*
  Types for the stack and machine-control executor.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package smc_pkg;

	typedef enum logic [3:0] {
		OP_NO_OPERATION       = 4'h0,
		OP_POP_PAIR           = 4'h1,
		OP_PUSH_STATUS        = 4'h2,
		OP_POP_STATUS         = 4'h3,
		OP_STACK_TOP_EXCHANGE = 4'h4,
		OP_STACK_POINTER_LOAD = 4'h5,
		OP_INTERRUPT_ENABLE   = 4'h6,
		OP_INTERRUPT_DISABLE  = 4'h7,
		OP_HALT               = 4'h8
	} op_type;

	typedef enum logic [1:0] {
		PAIR_BC    = 2'h0,
		PAIR_DE    = 2'h1,
		PAIR_HL    = 2'h2,
		PAIR_STACK = 2'h3
	} pair_type;

	typedef enum logic [2:0] {
		ST_IDLE = 3'h1,
		ST_EXEC = 3'h2,
		ST_HALT = 3'h4
	} state_type;

endpackage

//--- smc_stack_mem.sv
/*
  Byte-wide stack memory facing the executor's memory port.
  Assumes strobes on clk_sys and read data wanted in the cycle after memRd.
*/
`timescale 1ns/10ps
module smc_stack_mem (
	input  wire logic        clk_sys,
	input  wire logic [15:0] memAddr,
	input  wire logic [7:0]  memWrData,
	input  wire logic        memWr,
	input  wire logic        memRd,
	output logic [7:0]       memRdData
);
	logic [7:0] memArr [0:65535];
	logic [7:0] rdData_ff = 8'h00;
	// Outside a read answer the lines toggle, so a late sample sees garbage, not a stale byte
	always @(posedge clk_sys) begin
		if (memWr) begin
			memArr[memAddr] <= memWrData;
		end
		if (memRd) begin
			rdData_ff <= memArr[memAddr];
		end else begin
			rdData_ff <= ~rdData_ff;
		end
	end
	assign memRdData = rdData_ff;
endmodule // smc_stack_mem

//--- testbench.sv
/*
  Self-checking bench for the stack and machine-control executor.
  Assumes smc_pkg, the executor and smc_stack_mem are compiled first.
*/
`timescale 1ns/10ps
module testbench;
	import smc_pkg::*;
	logic       clk_sys = 1'b0, srst = 1'b1, opStart = 1'b0, wakeReq = 1'b0;
	logic       regWr = 1'b0, regRd = 1'b0;
	op_type     opCode = OP_NO_OPERATION;
	pair_type   pairSel = PAIR_BC;
	logic [3:0] regAddr = 4'h0;
	logic [7:0] regWrData = 8'h00;
	logic       busy, opDone, opRefused, halted, intEn, memWr, memRd;
	logic [15:0] memAddr, sp;
	logic [7:0] memWrData, memRdData, regRdData, rd;
	int         miscompares = 0, num_checks = 0;

	always #50 clk_sys = ~clk_sys;

	stack_machine_control_ops #(.STACK_W(16)) stack_machine_control_ops_inst (
		.clk_sys(clk_sys), .srst(srst), .opStart(opStart), .opCode(opCode), .pairSel(pairSel),
		.wakeReq(wakeReq), .busy_ff(busy), .opDone_ff(opDone), .opRefused_ff(opRefused),
		.halted_ff(halted), .intEnable_ff(intEn), .memAddr_ff(memAddr), .memWrData_ff(memWrData),
		.memWr_ff(memWr), .memRd_ff(memRd), .memRdData(memRdData), .regAddr(regAddr),
		.regWrData(regWrData), .regWr(regWr), .regRd(regRd), .regRdData_ff(regRdData));
	smc_stack_mem smc_stack_mem_inst (.clk_sys(clk_sys), .memAddr(memAddr), .memWrData(memWrData),
		.memWr(memWr), .memRd(memRd), .memRdData(memRdData));

	task automatic final_report();
		$display("checks %0d mismatches %0d", num_checks, miscompares);
		if (miscompares == 0 && num_checks > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask
	task automatic checkData(input logic [15:0] got, input logic [15:0] exp, input string what);
		num_checks++;
		if (got !== exp) begin
			miscompares++;
			$display("MISMATCH at %0t: %s got %h expected %h", $time, what, got, exp);
		end
	endtask
	task automatic checkCount(input int got, input int exp, input string what);
		num_checks++;
		if (got != exp) begin
			miscompares++;
			$display("MISMATCH at %0t: %s got %0d expected %0d", $time, what, got, exp);
		end
	endtask
	task automatic regWrite(input logic [3:0] a, input logic [7:0] d);
		@(posedge clk_sys);
		regWr <= 1'b1;
		regAddr <= a;
		regWrData <= d;
		@(posedge clk_sys);
		regWr <= 1'b0;
	endtask
	task automatic regRead(input logic [3:0] a, output logic [7:0] d);
		@(posedge clk_sys);
		regRd <= 1'b1;
		regAddr <= a;
		@(posedge clk_sys);
		regRd <= 1'b0;
		#1 d = regRdData;
	endtask
	task automatic readSp(output logic [15:0] s);
		logic [7:0] lo, hi;
		regRead(4'h8, lo);
		regRead(4'h9, hi);
		s = {hi, lo};
	endtask
	task automatic setSp(input logic [15:0] s);
		regWrite(4'h8, s[7:0]);
		regWrite(4'h9, s[15:8]);
	endtask
	// Length counts the sampling edges from acceptance to the one that sees opDone
	task automatic runOp(input op_type op, input pair_type ps, input int expLen);
		int n;
		@(posedge clk_sys);
		opStart <= 1'b1;
		opCode <= op;
		pairSel <= ps;
		@(posedge clk_sys);
		opStart <= 1'b0;
		n = 0;
		do begin
			@(negedge clk_sys);
			n++;
		end while (opDone !== 1'b1 && n < 40);
		checkCount(n, expLen, "op length");
		checkData(16'(busy), 16'(op == OP_HALT), "busy at done");
		@(negedge clk_sys);
		checkData(16'(opDone), 16'h0000, "done pulse");
	endtask

	task automatic testPopPair();
		for (int i = 0; i < 3; i++) begin
			regWrite(4'h1, 8'hD7);
			setSp(16'hFFFF);
			smc_stack_mem_inst.memArr[16'hFFFF] = 8'h10 + 8'(i);
			smc_stack_mem_inst.memArr[16'h0000] = 8'hA0 + 8'(i);
			runOp(OP_POP_PAIR, pair_type'(i), 10);
			regRead(4'(3 + 2 * i), rd);
			checkData(16'(rd), 16'h0010 + 16'(i), "pair low");
			regRead(4'(2 + 2 * i), rd);
			checkData(16'(rd), 16'h00A0 + 16'(i), "pair high");
			readSp(sp);
			checkData(sp, 16'h0001, "pointer after pop");
			regRead(4'h1, rd);
			checkData(16'(rd), 16'h00D7, "flags kept");
		end
		$display("test pop_pair done");
	endtask
	task automatic testRefused();
		int n;
		setSp(16'h1234);
		@(posedge clk_sys);
		opStart <= 1'b1;
		opCode <= OP_POP_PAIR;
		pairSel <= PAIR_STACK;
		@(posedge clk_sys);
		opStart <= 1'b0;
		n = 0;
		do begin
			@(negedge clk_sys);
			n++;
		end while (opRefused !== 1'b1 && n < 4);
		checkCount(n, 1, "refuse pulse");
		checkData(16'(busy), 16'h0000, "busy on refuse");
		readSp(sp);
		checkData(sp, 16'h1234, "pointer on refuse");
		$display("test refused done");
	endtask
	task automatic testStatus();
		logic [7:0] fin [2] = '{8'h28, 8'hFD};
		logic [7:0] pin [2] = '{8'h2A, 8'hFF};
		logic [7:0] fexp [2] = '{8'h02, 8'hD7};
		for (int i = 0; i < 2; i++) begin
			regWrite(4'h0, 8'h5C + 8'(i));
			regWrite(4'h1, fin[i]);
			setSp(16'h0001);
			runOp(OP_PUSH_STATUS, PAIR_BC, 11);
			checkData(16'(smc_stack_mem_inst.memArr[16'h0000]), 16'h005C + 16'(i), "pushed acc");
			checkData(16'(smc_stack_mem_inst.memArr[16'hFFFF]), 16'(fexp[i]), "pushed flags");
			readSp(sp);
			checkData(sp, 16'hFFFF, "pointer after push");
			regRead(4'h1, rd);
			checkData(16'(rd), 16'(fexp[i]), "flags after push");
			regWrite(4'h1, ~fexp[i]);
			setSp(16'h2000);
			smc_stack_mem_inst.memArr[16'h2000] = pin[i];
			smc_stack_mem_inst.memArr[16'h2001] = 8'h3C + 8'(i);
			runOp(OP_POP_STATUS, PAIR_BC, 10);
			regRead(4'h1, rd);
			checkData(16'(rd), 16'(fexp[i]), "popped flags");
			regRead(4'h0, rd);
			checkData(16'(rd), 16'h003C + 16'(i), "popped acc");
			readSp(sp);
			checkData(sp, 16'h2002, "pointer after status pop");
		end
		$display("test status done");
	endtask
	task automatic testExchangeLoad();
		regWrite(4'h6, 8'h12);
		regWrite(4'h7, 8'h34);
		setSp(16'h4000);
		smc_stack_mem_inst.memArr[16'h4000] = 8'hAB;
		smc_stack_mem_inst.memArr[16'h4001] = 8'hCD;
		runOp(OP_STACK_TOP_EXCHANGE, PAIR_BC, 18);
		regRead(4'h7, rd);
		checkData(16'(rd), 16'h00AB, "exchanged low");
		regRead(4'h6, rd);
		checkData(16'(rd), 16'h00CD, "exchanged high");
		checkData({smc_stack_mem_inst.memArr[16'h4001], smc_stack_mem_inst.memArr[16'h4000]},
			16'h1234, "stack top");
		readSp(sp);
		checkData(sp, 16'h4000, "pointer after exchange");
		regWrite(4'h6, 8'hBE);
		regWrite(4'h7, 8'hEF);
		runOp(OP_STACK_POINTER_LOAD, PAIR_BC, 5);
		readSp(sp);
		checkData(sp, 16'hBEEF, "pointer load");
		$display("test exchange_load done");
	endtask
	task automatic testIntHalt();
		int n;
		regWrite(4'h0, 8'h77);
		runOp(OP_INTERRUPT_ENABLE, PAIR_BC, 4);
		checkData(16'(intEn), 16'h0000, "enable delayed");
		runOp(OP_NO_OPERATION, PAIR_BC, 4);
		checkData(16'(intEn), 16'h0001, "enable after next");
		regRead(4'h0, rd);
		checkData(16'(rd), 16'h0077, "acc after no-op");
		runOp(OP_INTERRUPT_DISABLE, PAIR_BC, 4);
		checkData(16'(intEn), 16'h0000, "disable at once");
		runOp(OP_INTERRUPT_ENABLE, PAIR_BC, 4);
		runOp(OP_NO_OPERATION, PAIR_BC, 4);
		runOp(OP_HALT, PAIR_BC, 7);
		checkData(16'(halted), 16'h0001, "halted");
		regWrite(4'h0, 8'h00);
		regRead(4'h0, rd);
		checkData(16'(rd), 16'h0077, "acc kept in halt");
		readSp(sp);
		checkData(sp, 16'hBEEF, "pointer kept in halt");
		@(posedge clk_sys);
		wakeReq <= 1'b1;
		n = 0;
		do begin
			@(negedge clk_sys);
			n++;
		end while (halted !== 1'b0 && n < 20);
		wakeReq <= 1'b0;
		checkData(16'(halted), 16'h0000, "wake from halt");
		$display("test int_halt done");
	endtask
	// Halt with interrupts off ignores the wake pin; only a reset in mid-run leaves it
	task automatic testResetHalt();
		runOp(OP_INTERRUPT_DISABLE, PAIR_BC, 4);
		runOp(OP_HALT, PAIR_BC, 7);
		@(posedge clk_sys);
		wakeReq <= 1'b1;
		repeat (6) @(negedge clk_sys);
		checkData(16'(halted), 16'h0001, "wake ignored while disabled");
		@(posedge clk_sys);
		srst <= 1'b1;
		wakeReq <= 1'b0;
		repeat (2) @(posedge clk_sys);
		srst <= 1'b0;
		@(negedge clk_sys);
		checkData({busy, halted, intEn, opDone, opRefused, memWr, memRd, regRdData, 1'b0}, 16'h0000, "outputs after reset");
		checkData(memAddr, 16'h0000, "address after reset");
		readSp(sp);
		checkData(sp, 16'h0000, "pointer after mid-run reset");
		regRead(4'h0, rd);
		checkData(16'(rd), 16'h0000, "acc after mid-run reset");
		runOp(OP_NO_OPERATION, PAIR_BC, 4);
		$display("test reset_halt done");
	endtask

	initial begin
		repeat (20000) @(posedge clk_sys);
		miscompares++;
		$display("MISMATCH at %0t: watchdog expired", $time);
		final_report();
	end
	initial begin
		repeat (12) @(posedge clk_sys);
		srst <= 1'b0;
		readSp(sp);
		checkData(sp, 16'h0000, "pointer at reset");
		checkData(16'(intEn), 16'h0000, "interrupts at reset");
		testPopPair();
		testRefused();
		testStatus();
		testExchangeLoad();
		testIntHalt();
		testResetHalt();
		final_report();
	end
endmodule // testbench
